// ### logic/pbm_pkg.sv
// Purpose: Constants for the peripheral bus and shared pin selection block
// Assumes: One 100 MHz core clock, active high asynchronous reset
// Notes: Pin select bit positions follow the multimedia select register
package pbm_pkg;

  // ----------------------------------------------------------------------
  // Widths and field positions
  // ----------------------------------------------------------------------
  localparam int PBM_DATA_W = 8;
  localparam int PBM_CSEL_W = 5;
  localparam int PBM_HADDR_W = 13;
  localparam int PBM_SEL_PIN1_BIT = 6;
  localparam int PBM_SEL_PIN0_BIT = 5;
  localparam int PBM_STATUS_BIT = 4;
  localparam int PBM_LATCH_LO_BIT = 0;
  localparam int PBM_LATCH_HI_BIT = 6;

  // ----------------------------------------------------------------------
  // Reset values and the sprite-off field value
  // ----------------------------------------------------------------------
  localparam logic [7:0] PBM_DATA_RST = 8'h00;
  localparam logic [4:0] PBM_CSEL_RST = 5'h00;
  localparam logic [6:0] PBM_ROMHI_RST = 7'h00;
  localparam logic [1:0] PBM_SPRITE_OFF = 2'h0;

  // ----------------------------------------------------------------------
  // Shared pin functions
  // ----------------------------------------------------------------------
  typedef enum {
    PBM_FN_INPUT,
    PBM_FN_SPRITE,
    PBM_FN_CLKSEL,
    PBM_FN_TOKEN
  } pbm_pin_fn_type;

endpackage

// ### logic/pbm_peripheral_bus_pin_mux.sv
// Purpose: Peripheral data bus, strobes, ROM enable and shared pin mux
// Assumes: Host side decodes cycles into one-cycle requests on core_clk
// Notes: Straps are caught one cycle after reset release
//
// Behaviour
// - Drive three low clock selects, eight choices
// - Move host data both ways on bus
// - ROM address on bus, latched externally
// - Divide strap low disables bus ROM address
// - Output two low address bits as select
// - Upper select line is multimedia write strobe
// - DAC read strobe low on DAC read
// - DAC write strobe low on DAC write
// - BIOS strap picks ROM enable qualification
// - PCI divide-low ROM enable latches high address
// - Clock select three pin only in PCI
// - Shared pin one function selection
// - Shared pin zero function selection
// - Sync reset requests counter reset
// - Status input readable at status bit four
// - All sequencing from system clock
`timescale 1ns/1ps
module pbm_peripheral_bus_pin_mux
  import pbm_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic pci_mode,
  input wire logic bios_disable_strap,
  input wire logic clock_divide_strap,
  input wire logic [4:0] clock_select_value,
  input wire logic [1:0] host_reg_addr,
  input wire logic [7:0] host_wdata,
  input wire logic dac_rd_req,
  input wire logic dac_wr_req,
  input wire logic rom_space_decode,
  input wire logic bus_read,
  input wire logic [12:0] host_addr_14_2,
  input wire logic mm_wr_req,
  input wire logic [7:0] peripheral_data_bus_in,
  input wire logic [1:0] shared_pins_in,
  input wire logic pin1_select,
  input wire logic pin0_select,
  input wire logic [1:0] sprite_enable_field,
  input wire logic attribute_token_sel,
  input wire logic [1:0] sprite_data_out,
  input wire logic [1:0] token_status_out,
  output logic [7:0] peripheral_data_bus_out,
  output logic peripheral_data_bus_oe,
  output logic [1:0] peripheral_reg_select,
  output logic dac_read_strobe_n,
  output logic dac_write_strobe_n,
  output logic rom_enable_n,
  output logic address_latch_strobe,
  output logic [2:0] clock_select_low,
  output logic clock_select3_pin,
  output logic [1:0] shared_pins_out,
  output logic [1:0] shared_pins_oe,
  output logic [7:0] host_rdata,
  output logic [12:0] rom_address,
  output logic [7:0] input_status0,
  output logic sync_reset_req
);

  // ----------------------------------------------------------------------
  // Input synchronisers and strap capture
  // ----------------------------------------------------------------------
  logic [7:0] dbus_s1_q, dbus_s2_q;
  logic [1:0] pins_s1_q, pins_s2_q;
  logic strap_done_q, strap_done_d;
  logic bios_dis_q, bios_dis_d, divide_q, divide_d;
  logic rom_bus_en;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dbus_s1_q <= PBM_DATA_RST;
      dbus_s2_q <= PBM_DATA_RST;
      pins_s1_q <= 2'h0;
      pins_s2_q <= 2'h0;
    end else begin
      dbus_s1_q <= peripheral_data_bus_in;
      dbus_s2_q <= dbus_s1_q;
      pins_s1_q <= shared_pins_in;
      pins_s2_q <= pins_s1_q;
    end
  end

  always_comb begin
    strap_done_d = 1'b1;
    bios_dis_d = strap_done_q ? bios_dis_q : bios_disable_strap;
    divide_d = strap_done_q ? divide_q : clock_divide_strap;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      strap_done_q <= 1'b0;
      bios_dis_q <= 1'b0;
      divide_q <= 1'b0;
    end else begin
      strap_done_q <= strap_done_d;
      bios_dis_q <= bios_dis_d;
      divide_q <= divide_d;
    end
  end

  // Bus ROM address only in PCI mode with divide strap high
  assign rom_bus_en = pci_mode && divide_q;

  // ----------------------------------------------------------------------
  // Peripheral bus, strobes and ROM enable
  // ----------------------------------------------------------------------
  logic [7:0] dout_q, dout_d, rdata_q, rdata_d;
  logic doe_q, doe_d, rd_n_q, rd_n_d, wr_n_q, wr_n_d, rom_enable_n_n_q, rom_enable_n_n_d;
  logic ale_q, ale_d;
  logic rd_wait1_q, rd_wait1_d, rd_wait2_q, rd_wait2_d;
  logic [1:0] rs_q, rs_d;
  logic [6:0] romhi_q, romhi_d;
  logic [12:0] romaddr_q, romaddr_d;
  logic rom_hit;

  always_comb begin
    rom_hit = bios_dis_q ? rom_space_decode : (rom_space_decode && bus_read);
    rd_n_d = !dac_rd_req;
    wr_n_d = !dac_wr_req;
    rs_d = host_reg_addr;
    if (mm_wr_req) begin
      rs_d[1] = 1'b1;
    end
    doe_d = dac_wr_req || mm_wr_req;
    dout_d = doe_d ? host_wdata : dout_q;
    // DAC answer reaches the second sync stage two cycles after the strobe
    rd_wait1_d = !rd_n_q;
    rd_wait2_d = rd_wait1_q;
    rdata_d = rd_wait2_q ? dbus_s2_q : rdata_q;
    rom_enable_n_n_d = !rom_hit;
    ale_d = rom_bus_en && rom_hit;
    romhi_d = romhi_q;
    if (pci_mode && !divide_q && rom_hit) begin
      romhi_d = dbus_s2_q[PBM_LATCH_HI_BIT:PBM_LATCH_LO_BIT];
    end
    // Divide strap low in PCI: address from host bits 14..2
    if (pci_mode && !divide_q) begin
      romaddr_d = host_addr_14_2;
    end else begin
      romaddr_d = {romhi_q, host_addr_14_2[5:0]};
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dout_q <= PBM_DATA_RST;
      rdata_q <= PBM_DATA_RST;
      rd_wait1_q <= 1'b0;
      rd_wait2_q <= 1'b0;
      doe_q <= 1'b0;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      rom_enable_n_n_q <= 1'b1;
      ale_q <= 1'b0;
      rs_q <= 2'h0;
      romhi_q <= PBM_ROMHI_RST;
      romaddr_q <= 13'h0000;
    end else begin
      dout_q <= dout_d;
      rdata_q <= rdata_d;
      rd_wait1_q <= rd_wait1_d;
      rd_wait2_q <= rd_wait2_d;
      doe_q <= doe_d;
      rd_n_q <= rd_n_d;
      wr_n_q <= wr_n_d;
      rom_enable_n_n_q <= rom_enable_n_n_d;
      ale_q <= ale_d;
      rs_q <= rs_d;
      romhi_q <= romhi_d;
      romaddr_q <= romaddr_d;
    end
  end

  // ----------------------------------------------------------------------
  // Clock selects and shared pins
  // ----------------------------------------------------------------------
  pbm_pin_fn_type fn1, fn0;
  logic [2:0] csl_q, csl_d;
  logic cs3_q, cs3_d, sync_q, sync_d;
  logic [1:0] pout_q, pout_d, poe_q, poe_d;
  logic [7:0] ist_q, ist_d;

  always_comb begin
    csl_d = clock_select_value[2:0];
    cs3_d = pci_mode && clock_select_value[3];
    // Decoded every cycle; selection changes reach the registered pins at the next edge
    if (!pin1_select) fn1 = PBM_FN_INPUT;
    else if (sprite_enable_field == PBM_SPRITE_OFF) fn1 = PBM_FN_SPRITE;
    else if (attribute_token_sel) fn1 = PBM_FN_TOKEN;
    else fn1 = PBM_FN_CLKSEL;
    if (!pin0_select) fn0 = PBM_FN_INPUT;
    else if (sprite_enable_field == PBM_SPRITE_OFF) fn0 = PBM_FN_SPRITE;
    else if (attribute_token_sel) fn0 = PBM_FN_TOKEN;
    else fn0 = PBM_FN_CLKSEL;
    case (fn1)
      PBM_FN_SPRITE: pout_d[1] = sprite_data_out[1];
      PBM_FN_CLKSEL: pout_d[1] = clock_select_value[4];
      PBM_FN_TOKEN: pout_d[1] = token_status_out[1];
      default: pout_d[1] = 1'b0;
    endcase
    case (fn0)
      PBM_FN_SPRITE: pout_d[0] = sprite_data_out[0];
      PBM_FN_CLKSEL: pout_d[0] = clock_select_value[3];
      PBM_FN_TOKEN: pout_d[0] = token_status_out[0];
      default: pout_d[0] = 1'b0;
    endcase
    poe_d = {fn1 != PBM_FN_INPUT, fn0 != PBM_FN_INPUT};
    sync_d = (fn0 == PBM_FN_INPUT) && pins_s2_q[0];
    ist_d = 8'h00;
    ist_d[PBM_STATUS_BIT] = (fn1 == PBM_FN_INPUT) && pins_s2_q[1];
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      csl_q <= 3'h0;
      cs3_q <= 1'b0;
      pout_q <= 2'h0;
      poe_q <= 2'h0;
      sync_q <= 1'b0;
      ist_q <= 8'h00;
    end else begin
      csl_q <= csl_d;
      cs3_q <= cs3_d;
      pout_q <= pout_d;
      poe_q <= poe_d;
      sync_q <= sync_d;
      ist_q <= ist_d;
    end
  end

  assign peripheral_data_bus_out = dout_q;
  assign peripheral_data_bus_oe = doe_q;
  assign peripheral_reg_select = rs_q;
  assign dac_read_strobe_n = rd_n_q;
  assign dac_write_strobe_n = wr_n_q;
  assign rom_enable_n = rom_enable_n_n_q;
  assign address_latch_strobe = ale_q;
  assign clock_select_low = csl_q;
  assign clock_select3_pin = cs3_q;
  assign shared_pins_out = pout_q;
  assign shared_pins_oe = poe_q;
  assign host_rdata = rdata_q;
  assign rom_address = romaddr_q;
  assign input_status0 = ist_q;
  assign sync_reset_req = sync_q;

endmodule

// ### testbench/pbm_checker.sv
// Purpose: Port assertions for the peripheral bus pin mux
// Assumes: Straps held steady outside reset
// Notes: Bound to the block after the module
`timescale 1ns/1ps
module pbm_checker
  import pbm_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic dac_rd_req,
  input wire logic dac_wr_req,
  input wire logic mm_wr_req,
  input wire logic pci_mode,
  input wire logic rom_space_decode,
  input wire logic bus_read,
  input wire logic bios_disable_strap,
  input wire logic pin1_select,
  input wire logic pin0_select,
  input wire logic attribute_token_sel,
  input wire logic peripheral_data_bus_oe,
  input wire logic dac_read_strobe_n,
  input wire logic dac_write_strobe_n,
  input wire logic rom_enable_n,
  input wire logic clock_select3_pin,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] peripheral_data_bus_out,
  input wire logic [4:0] clock_select_value,
  input wire logic [1:0] host_reg_addr,
  input wire logic [1:0] sprite_enable_field,
  input wire logic [1:0] sprite_data_out,
  input wire logic [1:0] token_status_out,
  input wire logic [1:0] peripheral_reg_select,
  input wire logic [1:0] shared_pins_out,
  input wire logic [1:0] shared_pins_oe
);
  // ------------------------------------------
  // Expected values
  // ------------------------------------------
  logic armed_q;
  logic bios_cap_q;
  wire logic rom_on = rom_space_decode && (bus_read || bios_cap_q);
  wire logic cs3 = clock_select_value[3];
  wire logic pin0_exp = attribute_token_sel ? token_status_out[0] : cs3;
  wire logic pin1_exp = attribute_token_sel ? token_status_out[1] : clock_select_value[4];
  // Strap copy taken at the first edge after reset
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      armed_q <= 1'b0;
      bios_cap_q <= 1'b0;
    end else begin
      armed_q <= 1'b1;
      if (!armed_q) begin
        bios_cap_q <= bios_disable_strap;
      end
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_wr_drive;
    !dac_write_strobe_n && peripheral_data_bus_oe &&
      peripheral_data_bus_out == $past(host_wdata);
  endsequence
  property p_wr; dac_wr_req |=> s_wr_drive; endproperty
  a_wr: assert property (p_wr) else $error("write not driven");
  property p_wr_idle; !dac_wr_req |=> dac_write_strobe_n; endproperty
  a_wr_idle: assert property (p_wr_idle) else $error("stray write");
  property p_rd; dac_rd_req |=> !dac_read_strobe_n; endproperty
  a_rd: assert property (p_rd) else $error("read strobe missing");
  property p_rd_idle; !dac_rd_req |=> dac_read_strobe_n; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read");
  property p_rsel; dac_rd_req && !mm_wr_req |=> peripheral_reg_select == $past(host_reg_addr);
  endproperty
  a_rsel: assert property (p_rsel) else $error("bad select");
  property p_mm; mm_wr_req |=> peripheral_reg_select[1]; endproperty
  a_mm: assert property (p_mm) else $error("no mm strobe");
  property p_cs3; pci_mode |=> clock_select3_pin == $past(cs3); endproperty
  a_cs3: assert property (p_cs3) else $error("bad cs3 pin");
  property p_rom; 1'h1 |=> rom_enable_n == !$past(rom_on); endproperty
  a_rom: assert property (p_rom) else $error("bad rom enable");
  property p_pin0; pin0_select && sprite_enable_field != 2'h0 |=>
    shared_pins_oe[0] && shared_pins_out[0] == $past(pin0_exp); endproperty
  a_pin0: assert property (p_pin0) else $error("bad pin0 out");
  property p_pin_in; !pin0_select |=> !shared_pins_oe[0]; endproperty
  a_pin_in: assert property (p_pin_in) else $error("input pin driven");
  property p_pin1; pin1_select && sprite_enable_field != 2'h0 |=>
    shared_pins_oe[1] && shared_pins_out[1] == $past(pin1_exp); endproperty
  a_pin1: assert property (p_pin1) else $error("bad pin1 out");
  property p_pin1_in; !pin1_select |=> !shared_pins_oe[1]; endproperty
  a_pin1_in: assert property (p_pin1_in) else $error("input pin1 driven");
  property p_sprite; pin1_select && pin0_select && sprite_enable_field == 2'h0 |=>
    shared_pins_oe == 2'h3 && shared_pins_out == $past(sprite_data_out); endproperty
  a_sprite: assert property (p_sprite) else $error("bad sprite out");
endmodule
bind pbm_peripheral_bus_pin_mux pbm_checker u_chk (.*);

// ### testbench/pbm_far_model.sv
// Purpose: Far-side bus model, DAC answers reads
// Assumes: Bus floats when neither side drives
// Notes: Idle bus rests at its pull-up level
`timescale 1ns/1ps
module pbm_far_model (
  input wire logic dac_read_strobe_n,
  input wire logic peripheral_data_bus_oe,
  input wire logic [7:0] peripheral_data_bus_out,
  output logic [7:0] peripheral_data_bus_in
);
  // Block drive wins; else DAC answers while its read strobe is low; else pull-ups
  assign peripheral_data_bus_in = peripheral_data_bus_oe ? peripheral_data_bus_out :
    !dac_read_strobe_n ? 8'h5a : 8'hff;
endmodule

// ### testbench/pbm_peripheral_bus_pin_mux_bench.sv
// Purpose: Bench for the peripheral bus pin mux
// Assumes: Inputs move 1 ns after the edge
// Notes: Straps change only in reset
`timescale 1ns/1ps
module pbm_peripheral_bus_pin_mux_bench;
  import pbm_pkg::*;
  logic core_clk = 1'h0, reset = 1'h1, pci_mode = 1'h1, clock_divide_strap = 1'h1;
  logic bios_disable_strap, dac_rd_req, dac_wr_req, mm_wr_req, rom_space_decode, bus_read;
  logic pin1_select, pin0_select, attribute_token_sel, peripheral_data_bus_oe;
  logic dac_read_strobe_n, dac_write_strobe_n, rom_enable_n, address_latch_strobe;
  logic clock_select3_pin, sync_reset_req;
  logic [1:0] host_reg_addr, pin_ext, sprite_enable_field, sprite_data_out, token_status_out;
  logic [1:0] peripheral_reg_select, shared_pins_out, shared_pins_oe, shared_pins_in, e;
  logic [2:0] clock_select_low;
  logic [4:0] clock_select_value;
  logic [7:0] host_wdata, peripheral_data_bus_in, peripheral_data_bus_out, host_rdata;
  logic [7:0] input_status0;
  logic [12:0] host_addr_14_2 = 13'h0000, rom_address;
  int num_errors = 0, checked = 0;
  assign shared_pins_in = (shared_pins_oe & shared_pins_out) | (~shared_pins_oe & pin_ext);
  pbm_peripheral_bus_pin_mux uut (.*);
  pbm_far_model far (.*);
  always #5 core_clk = ~core_clk;
  task automatic step(int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic do_reset(logic bios, logic div = 1'h1);
    reset = 1'h1;
    bios_disable_strap = bios;
    clock_divide_strap = div;
    step(20);
    reset = 1'h0;
    step(2);
  endtask
  task automatic t_dac();
    host_wdata = 8'ha5;
    host_reg_addr = 2'h2;
    dac_wr_req = 1'h1;
    step();
    dac_wr_req = 1'h0;
    dac_rd_req = 1'h1;
    host_reg_addr = 2'h1;
    chk(dac_write_strobe_n, 1'h0);
    chk(peripheral_data_bus_out, 8'ha5);
    step();
    dac_rd_req = 1'h0;
    mm_wr_req = 1'h1;
    chk(dac_read_strobe_n, 1'h0);
    chk(peripheral_reg_select, 2'h1);
    step();
    mm_wr_req = 1'h0;
    chk(peripheral_reg_select[1], 1'h1);
    chk({dac_read_strobe_n, dac_write_strobe_n}, 2'h3);
    step(2);
    chk(host_rdata, 8'h5a);
  endtask
  task automatic t_rom(logic bios);
    do_reset(bios);
    for (int i = 0; i < 4; i++) begin
      rom_space_decode = i[1];
      bus_read = i[0];
      step();
      chk(rom_enable_n, !(i[1] && (i[0] || bios)));
      chk(address_latch_strobe, i[1] && (i[0] || bios));
    end
  endtask
  task automatic t_div();
    do_reset(1'h1, 1'h0);
    host_addr_14_2 = 13'h1abc;
    rom_space_decode = 1'h1;
    bus_read = 1'h1;
    step();
    chk(rom_address, 13'h1abc);
    chk(address_latch_strobe, 1'h0);
    chk(rom_enable_n, 1'h0);
    pci_mode = 1'h0;
    clock_select_value = 5'h08;
    step();
    chk(rom_address, 13'h1ffc);
    chk(clock_select3_pin, 1'h0);
    pci_mode = 1'h1;
    step();
    chk(clock_select3_pin, 1'h1);
  endtask
  task automatic t_pins();
    sprite_data_out = 2'h2;
    token_status_out = 2'h1;
    for (int k = 0; k < 8; k++) begin
      pin1_select = k[0];
      pin0_select = k[0];
      sprite_enable_field = {1'h0, k[1]};
      attribute_token_sel = k[2];
      clock_select_value = 5'(k * 9);
      e = !k[1] ? sprite_data_out : k[2] ? token_status_out : clock_select_value[4:3];
      step();
      chk(clock_select_low, clock_select_value[2:0]);
      chk(clock_select3_pin, clock_select_value[3]);
      chk(shared_pins_oe, {2{k[0]}});
      if (k[0]) chk(shared_pins_out, e);
    end
    pin0_select = 1'h0;
    step();
    chk(shared_pins_oe, 2'h2);
    pin1_select = 1'h0;
    for (int v = 0; v < 2; v++) begin
      pin_ext = {2{v[0]}};
      step(4);
      chk(input_status0[PBM_STATUS_BIT], v[0]);
      chk(sync_reset_req, v[0]);
    end
    pin1_select = 1'h1;
    step(4);
    chk(input_status0[PBM_STATUS_BIT], 1'h0);
  endtask
  task automatic results();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    results();
  end
  initial begin
    {dac_rd_req, dac_wr_req, mm_wr_req, rom_space_decode, bus_read, pin1_select, pin0_select,
      attribute_token_sel, host_reg_addr, pin_ext, sprite_enable_field, sprite_data_out,
      token_status_out, clock_select_value, host_wdata} = 31'h0000_0000;
    do_reset(1'h0);
    t_dac();
    t_rom(1'h0);
    t_rom(1'h1);
    t_div();
    t_pins();
    results();
  end
endmodule
